/* File: hw/sis_pkg.sv */
package sis_pkg;
  // Register port geometry
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 8;
  localparam logic [15:0] A_SEC_STAT1  = 16'h1106;
  localparam logic [15:0] A_SEC_STAT0  = 16'h1107;
  localparam logic [15:0] A_IRQ_STAT   = 16'h110B;
  localparam logic [15:0] A_IRQ_EN2    = 16'h110D;
  localparam logic [15:0] A_IRQ_EN1    = 16'h110E;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  // Section status byte 0 and interrupt status fields
  localparam int          B_LOS        = 0;
  localparam int          B_SEF        = 1;
  localparam int          B_LOF        = 2;
  // Section status byte 1 field
  localparam int          B_MS_AIS     = 0;
  // Enable byte 2 fields and writable mask
  localparam int          B_EN_RDI     = 0;
  localparam int          B_EN_AIS     = 1;
  localparam logic [7:0]  EN2_MASK     = 8'h03;
  // Enable byte 1 fields
  localparam int          B_EN_KNEW    = 0;
  localparam int          B_EN_KUNST   = 1;
  localparam int          B_EN_CAP     = 2;
  localparam int          B_EN_TIM     = 3;
  localparam int          B_EN_TRNEW   = 4;
  localparam int          B_EN_TRUNST  = 5;
  localparam int          B_EN_S1UNST  = 6;
  localparam int          B_EN_S1NEW   = 7;
  // Persistence counts, in frames or messages
  localparam int          CNT_W        = 4;
  localparam logic [3:0]  S1_PERSIST   = 4'h8;
  localparam logic [3:0]  PERSIST_SHRT = 4'h3;
  localparam logic [3:0]  PERSIST_LONG = 4'h5;
  localparam logic [3:0]  CNT_ONE      = 4'h1;
endpackage

/* File: hw/sis_section_irq.sv */
`timescale 1ns/10ps
// Operation
// - LOF declare or clear sets status bit 2
// - SEF declare or clear sets status bit 1
// - LOS declare or clear sets status bit 0
// - Reading status register clears its bits
// - Status one means change since last read
// - Live LOS SEF LOF in status byte 0
// - Enable byte2 bit1 gates MS-AIS change interrupt
// - Enable byte2 bit0 gates MS-RDI; upper bits zero
// - Live MS-AIS readable in status byte 1 bit0
// - Enables read/write, one enables, reset zero
// - New S1 accepted after eight equal frames
// - Enable bit7 raises interrupt on new S1
// - Enable bit6 gates S1 unstable change
// - Enable bit5 gates trace unstable change
// - Enable bit4 gates new trace message
// - Bits 3..0 gate TIM, capture, K events
// - Trace accepted after three or five repeats
// - Capture done fires on last stored byte
// - K1K2 accepted after three or five frames
module sis_section_irq #(
  parameter int TR_W = 16
) (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  input  wire logic [sis_pkg::ADDR_W-1:0] addr,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  input  wire logic [sis_pkg::DATA_W-1:0] wdata,
  output logic      [sis_pkg::DATA_W-1:0] rdata,
  input  wire logic                       los_dfct,
  input  wire logic                       sef_dfct,
  input  wire logic                       lof_dfct,
  input  wire logic                       ms_ais_dfct,
  input  wire logic                       ms_rdi_dfct,
  input  wire logic                       s1_unst_dfct,
  input  wire logic                       tr_unst_dfct,
  input  wire logic                       ms_tim_dfct,
  input  wire logic                       k_unst_dfct,
  input  wire logic                       frame_stb,
  input  wire logic [7:0]                 s1_byte,
  input  wire logic [15:0]                k1k2_word,
  input  wire logic                       tr_msg_stb,
  input  wire logic [TR_W-1:0]            tr_msg_sig,
  input  wire logic                       overhead_capture_complete,
  input  wire logic                       persist_long,
  output logic                            irq,
  output logic      [7:0]                 s1_value,
  output logic      [15:0]                k1k2_value,
  output logic      [TR_W-1:0]            tr_value
);
  import sis_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]       en1;
  logic [7:0]       en2;
  logic [2:0]       irq_stat;
  logic [8:0]       dfct_prev;
  logic [7:0]       s1_cand;
  logic [CNT_W-1:0] s1_cnt;
  logic [15:0]      k_cand;
  logic [CNT_W-1:0] k_cnt;
  logic [TR_W-1:0]  tr_cand;
  logic [CNT_W-1:0] tr_cnt;
  wire  [8:0]       dfct_now;
  wire  [8:0]       dfct_ch;
  wire              rd_stat;
  wire              wr_en1;
  wire              wr_en2;
  wire  [3:0]       rep_lim;
  wire              s1_match;
  wire              s1_new;
  wire              k_match;
  wire              k_new;
  wire              tr_match;
  wire              tr_new;
  wire  [7:0]       ev1;
  wire  [1:0]       ev2;
  wire              next_irq;
  wire  [7:0]       next_rdata;
  wire  [2:0]       next_stat;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  assign rd_stat = rd_stb && (addr == A_IRQ_STAT);
  assign wr_en1  = wr_stb && (addr == A_IRQ_EN1);
  assign wr_en2  = wr_stb && (addr == A_IRQ_EN2);

  // Change detection on every defect level: {K,TIM,TR,S1,RDI,AIS,LOF,SEF,LOS}
  assign dfct_now = {k_unst_dfct, ms_tim_dfct, tr_unst_dfct, s1_unst_dfct,
                     ms_rdi_dfct, ms_ais_dfct, lof_dfct, sef_dfct, los_dfct};
  assign dfct_ch  = dfct_now ^ dfct_prev;

  // Sticky change status; set wins over clear-on-read
  assign next_stat = (rd_stat ? 3'h0 : irq_stat) | dfct_ch[2:0];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dfct_prev <= 9'h000;
      irq_stat  <= 3'h0;
    end else begin
      dfct_prev <= dfct_now;
      irq_stat  <= next_stat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable registers, reset to zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en1 <= RST_BYTE;
      en2 <= RST_BYTE;
    end else begin
      if (wr_en1) begin
        en1 <= wdata;
      end
      if (wr_en2) begin
        en2 <= wdata & EN2_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // S1 persistence: same value in eight consecutive frames
  assign s1_match = (s1_byte == s1_cand);
  assign s1_new   = frame_stb && s1_match && (s1_cnt == S1_PERSIST - CNT_ONE)
                    && (s1_byte != s1_value);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_cand  <= RST_BYTE;
      s1_cnt   <= '0;
      s1_value <= RST_BYTE;
    end else if (frame_stb) begin
      s1_cand <= s1_byte;
      if (!s1_match) begin
        s1_cnt <= CNT_ONE;
      end else if (s1_cnt < S1_PERSIST) begin
        s1_cnt <= s1_cnt + CNT_ONE;
      end
      if (s1_new) begin
        s1_value <= s1_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // K1/K2 and trace persistence: three or five repeats
  assign rep_lim  = persist_long ? PERSIST_LONG : PERSIST_SHRT;
  assign k_match  = (k1k2_word == k_cand);
  assign k_new    = frame_stb && k_match && (k_cnt == rep_lim - CNT_ONE)
                    && (k1k2_word != k1k2_value);
  assign tr_match = (tr_msg_sig == tr_cand);
  assign tr_new   = tr_msg_stb && tr_match && (tr_cnt == rep_lim - CNT_ONE)
                    && (tr_msg_sig != tr_value);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      k_cand     <= 16'h0000;
      k_cnt      <= '0;
      k1k2_value <= 16'h0000;
    end else if (frame_stb) begin
      k_cand <= k1k2_word;
      if (!k_match) begin
        k_cnt <= CNT_ONE;
      end else if (k_cnt < PERSIST_LONG) begin
        k_cnt <= k_cnt + CNT_ONE;
      end
      if (k_new) begin
        k1k2_value <= k1k2_word;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tr_cand  <= '0;
      tr_cnt   <= '0;
      tr_value <= '0;
    end else if (tr_msg_stb) begin
      tr_cand <= tr_msg_sig;
      if (!tr_match) begin
        tr_cnt <= CNT_ONE;
      end else if (tr_cnt < PERSIST_LONG) begin
        tr_cnt <= tr_cnt + CNT_ONE;
      end
      if (tr_new) begin
        tr_value <= tr_msg_sig;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt sources gated by enables, one-cycle registered pulse
  assign ev1 = {s1_new, dfct_ch[5], dfct_ch[6], tr_new, dfct_ch[7],
                overhead_capture_complete, dfct_ch[8], k_new};
  assign ev2 = {dfct_ch[3], dfct_ch[4]};
  assign next_irq = (|(ev1 & en1)) | (|(ev2 & en2[1:0]));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered; unmapped addresses read zero
  assign next_rdata =
    (addr == A_IRQ_STAT)  ? {5'h00, irq_stat} :
    (addr == A_SEC_STAT0) ? {5'h00, lof_dfct, sef_dfct, los_dfct} :
    (addr == A_SEC_STAT1) ? {7'h00, ms_ais_dfct} :
    (addr == A_IRQ_EN1)   ? en1 :
    (addr == A_IRQ_EN2)   ? en2 : RST_BYTE;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= RST_BYTE;
    end else if (rd_stb) begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_lof_change;
    $changed(lof_dfct) |=> irq_stat[B_LOF];
  endproperty
  a_lof_change: assert property (p_lof_change) else $error("LOF change not latched");

  property p_sef_change;
    $changed(sef_dfct) |=> irq_stat[B_SEF];
  endproperty
  a_sef_change: assert property (p_sef_change) else $error("SEF change not latched");

  property p_los_change;
    $changed(los_dfct) |=> irq_stat[B_LOS];
  endproperty
  a_los_change: assert property (p_los_change) else $error("LOS change not latched");

  property p_read_clears;
    rd_stat && (dfct_ch[2:0] == 3'h0) |=> (irq_stat == 3'h0) && (rdata[2:0] == $past(irq_stat));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("Status not cleared by read");

  property p_no_event_zero;
    (irq_stat[B_LOS] == 1'b0) && !rd_stat && !$changed(los_dfct) ##1 !$changed(los_dfct)
      |-> irq_stat[B_LOS] == 1'b0;
  endproperty
  a_no_event_zero: assert property (p_no_event_zero) else $error("Status set without event");

  property p_live_stat0;
    rd_stb && (addr == A_SEC_STAT0)
      |=> rdata == {5'h00, $past(lof_dfct), $past(sef_dfct), $past(los_dfct)};
  endproperty
  a_live_stat0: assert property (p_live_stat0) else $error("Status byte 0 wrong");

  property p_ais_irq;
    $changed(ms_ais_dfct) && en2[B_EN_AIS] |=> irq;
  endproperty
  a_ais_irq: assert property (p_ais_irq) else $error("MS-AIS change lost");

  property p_rdi_irq;
    $changed(ms_rdi_dfct) && en2[B_EN_RDI] |=> irq;
  endproperty
  a_rdi_irq: assert property (p_rdi_irq) else $error("MS-RDI change lost");

  property p_ais_live;
    rd_stb && (addr == A_SEC_STAT1) |=> rdata == {7'h00, $past(ms_ais_dfct)};
  endproperty
  a_ais_live: assert property (p_ais_live) else $error("Status byte 1 wrong");

  property p_en2_upper;
    rd_stb && (addr == A_IRQ_EN2) |=> rdata[7:2] == 6'h00;
  endproperty
  a_en2_upper: assert property (p_en2_upper) else $error("Enable byte 2 upper bits set");

  property p_en1_write;
    wr_en1 ##1 !wr_stb ##1 (rd_stb && (addr == A_IRQ_EN1))
      |=> rdata == $past(wdata, 3);
  endproperty
  a_en1_write: assert property (p_en1_write) else $error("Enable byte 1 readback wrong");

  sequence s_s1_run;
    frame_stb && s1_match && (s1_cnt == S1_PERSIST - CNT_ONE);
  endsequence
  property p_s1_accept;
    s1_new |-> s_s1_run;
  endproperty
  a_s1_accept: assert property (p_s1_accept) else $error("S1 accepted early");

  property p_s1_irq;
    s1_new && en1[B_EN_S1NEW] |=> irq ##1 (s1_value == $past(s1_byte, 2));
  endproperty
  a_s1_irq: assert property (p_s1_irq) else $error("New S1 interrupt missing");

  property p_s1unst_irq;
    $changed(s1_unst_dfct) && en1[B_EN_S1UNST] |=> irq;
  endproperty
  a_s1unst_irq: assert property (p_s1unst_irq) else $error("S1 unstable change lost");

  property p_trunst_irq;
    $changed(tr_unst_dfct) && en1[B_EN_TRUNST] |=> irq;
  endproperty
  a_trunst_irq: assert property (p_trunst_irq) else $error("Trace unstable change lost");

  property p_trnew_irq;
    tr_new && en1[B_EN_TRNEW] |=> irq;
  endproperty
  a_trnew_irq: assert property (p_trnew_irq) else $error("New trace interrupt missing");

  property p_tim_irq;
    $changed(ms_tim_dfct) && en1[B_EN_TIM] |=> irq;
  endproperty
  a_tim_irq: assert property (p_tim_irq) else $error("TIM change lost");

  property p_kunst_irq;
    $changed(k_unst_dfct) && en1[B_EN_KUNST] |=> irq;
  endproperty
  a_kunst_irq: assert property (p_kunst_irq) else $error("K unstable change lost");

  property p_knew_irq;
    k_new && en1[B_EN_KNEW] |=> irq;
  endproperty
  a_knew_irq: assert property (p_knew_irq) else $error("New K1K2 interrupt missing");

  property p_cap_irq;
    overhead_capture_complete && en1[B_EN_CAP] |=> irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("Capture done interrupt missing");

  property p_tr_accept;
    tr_new |=> tr_value == $past(tr_msg_sig);
  endproperty
  a_tr_accept: assert property (p_tr_accept) else $error("Trace value not taken");

  sequence s_k_take;
    frame_stb && k_match && (k1k2_word != k1k2_value);
  endsequence
  property p_k_accept;
    k_new |-> s_k_take ##1 (k1k2_value == $past(k1k2_word));
  endproperty
  a_k_accept: assert property (p_k_accept) else $error("K1K2 value not taken");

  property p_set_wins;
    rd_stat && (dfct_ch[2:0] != 3'h0)
      |=> (irq_stat & $past(dfct_ch[2:0])) == $past(dfct_ch[2:0]);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Event lost on clearing read");

  property p_no_irq_masked;
    (en1 == 8'h00) && (en2 == 8'h00) |=> !irq;
  endproperty
  a_no_irq_masked: assert property (p_no_irq_masked) else $error("Interrupt while masked");
endmodule

/* File: tb/sis_section_irq_tb.sv */
`timescale 1ns/10ps
module sis_section_irq_tb;
  import sis_pkg::*;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] addr = '0, k1k2_word = '0, tr_msg_sig = '0, v, w;
  logic [7:0]  wdata = '0, s1_byte = '0;
  logic        wr_stb = 1'b0, rd_stb = 1'b0, rd_pend = 1'b0;
  logic        los_dfct = 1'b0, sef_dfct = 1'b0, lof_dfct = 1'b0;
  logic        ms_ais_dfct = 1'b0, ms_rdi_dfct = 1'b0, s1_unst_dfct = 1'b0;
  logic        tr_unst_dfct = 1'b0, ms_tim_dfct = 1'b0, k_unst_dfct = 1'b0;
  logic        frame_stb = 1'b0, tr_msg_stb = 1'b0, persist_long = 1'b0;
  logic        overhead_capture_complete = 1'b0;
  logic        irq;
  logic [7:0]  rdata, s1_value;
  logic [15:0] k1k2_value, tr_value, got;
  logic [15:0] cur [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] en_a [7];
  int          en_b [7];
  int          err_total = 0, checked = 0, seed = 32'hEBFC, n, kind;
  logic [7:0]  exp_rd [$];
  string       exp_irq [$];

  sis_section_irq i_sis_section_irq (
    .mclk, .rstn, .addr, .wr_stb, .rd_stb, .wdata, .rdata, .los_dfct, .sef_dfct,
    .lof_dfct, .ms_ais_dfct, .ms_rdi_dfct, .s1_unst_dfct, .tr_unst_dfct, .ms_tim_dfct,
    .k_unst_dfct, .frame_stb, .s1_byte, .k1k2_word, .tr_msg_stb, .tr_msg_sig,
    .overhead_capture_complete, .persist_long, .irq, .s1_value, .k1k2_value, .tr_value
  );

  // Free-running 20 MHz clock
  initial begin
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One register write, strobe held for one edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // One register read; the expected byte is noted for the monitor
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_rd.push_back(e);
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask

  task automatic set_sec(input int b, input logic x);
    case (b)
      0: los_dfct <= x;
      1: sef_dfct <= x;
      default: lof_dfct <= x;
    endcase
  endtask

  task automatic set_src(input int i, input logic x);
    case (i)
      0: ms_ais_dfct <= x;
      1: ms_rdi_dfct <= x;
      2: s1_unst_dfct <= x;
      3: tr_unst_dfct <= x;
      4: ms_tim_dfct <= x;
      5: k_unst_dfct <= x;
      default: overhead_capture_complete <= x;
    endcase
  endtask

  // Declare then clear a source (capture done is a single pulse)
  task automatic fire(input int i, input bit en);
    if (en) exp_irq.push_back("rise");
    set_src(i, 1'b1);
    step(1);
    if (i == 6) set_src(i, 1'b0);
    if (i == 0) rd(A_SEC_STAT1, 8'h01);
    step(3);
    if (i < 6) begin
      if (en) exp_irq.push_back("fall");
      set_src(i, 1'b0);
      step(3);
      if (i == 0) rd(A_SEC_STAT1, 8'h00);
    end
  endtask

  // One frame or trace message carrying x for the selected kind only
  task automatic send(input int k, input logic [15:0] x);
    @(posedge mclk);
    if (k == 0) s1_byte <= x[7:0];
    if (k == 1) k1k2_word <= x;
    if (k == 2) tr_msg_sig <= x;
    if (k == 2) tr_msg_stb <= 1'b1;
    else frame_stb <= 1'b1;
    @(posedge mclk);
    frame_stb <= 1'b0;
    tr_msg_stb <= 1'b0;
    step(2);
  endtask

  task automatic wrap_up;
    if (exp_rd.size() != 0 || exp_irq.size() != 0) begin
      err_total++;
      $display("BAD pending expected 0 seen %0d", exp_rd.size() + exp_irq.size());
    end
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: read data one edge after the strobe, irq pulses against notes
  always @(posedge mclk) rd_pend <= rd_stb;
  always @(negedge mclk) begin
    if (rd_pend) chk("rdata", {8'h00, exp_rd.pop_front()}, {8'h00, rdata});
    if (irq === 1'b1) begin
      checked++;
      if (exp_irq.size() == 0) begin
        err_total++;
        $display("BAD irq expected 0 seen 1");
      end else void'(exp_irq.pop_front());
    end
  end

  // Hang guard
  initial begin
    step(20000);
    err_total++;
    $display("BAD watchdog expected end seen timeout");
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    en_a = '{A_IRQ_EN2, A_IRQ_EN2, A_IRQ_EN1, A_IRQ_EN1, A_IRQ_EN1, A_IRQ_EN1, A_IRQ_EN1};
    en_b = '{B_EN_AIS, B_EN_RDI, B_EN_S1UNST, B_EN_TRUNST, B_EN_TIM, B_EN_KUNST, B_EN_CAP};
    step(10);
    rstn <= 1'b1;
    rd(A_IRQ_EN2, RST_BYTE);
    rd(A_IRQ_EN1, RST_BYTE);
    rd(A_IRQ_STAT, 8'h00);
    rd(16'h1234, 8'h00);
    wr(A_IRQ_EN2, 8'hFF);
    rd(A_IRQ_EN2, EN2_MASK);
    v = 16'($random(seed));
    wr(A_IRQ_EN1, v[7:0]);
    rd(A_IRQ_EN1, v[7:0]);
    wr(A_IRQ_EN1, 8'h00);
    wr(A_IRQ_EN2, 8'h00);
    $display("test registers done");
    for (int b = 0; b < 3; b++) begin
      set_sec(b, 1'b1);
      step(3);
      rd(A_IRQ_STAT, 8'h01 << b);
      rd(A_IRQ_STAT, 8'h00);
      rd(A_SEC_STAT0, 8'h01 << b);
      set_sec(b, 1'b0);
      step(3);
      rd(A_IRQ_STAT, 8'h01 << b);
      rd(A_SEC_STAT0, 8'h00);
    end
    // Change of loss of signal lands in the very cycle of a clearing read
    set_sec(0, 1'b1);
    step(3);
    @(posedge mclk);
    addr <= A_IRQ_STAT;
    rd_stb <= 1'b1;
    los_dfct <= 1'b0;
    exp_rd.push_back(8'h01);
    @(posedge mclk);
    rd_stb <= 1'b0;
    step(3);
    rd(A_IRQ_STAT, 8'h01);
    rd(A_IRQ_STAT, 8'h00);
    $display("test change status done");
    for (int i = 0; i < 7; i++) begin
      wr(A_IRQ_EN1, 8'h00);
      wr(A_IRQ_EN2, 8'h00);
      wr(en_a[i], 8'h01 << en_b[i]);
      rd(en_a[i], 8'h01 << en_b[i]);
      fire(i, 1'b1);
      wr(en_a[i], 8'h00);
      fire(i, 1'b0);
    end
    $display("test enable gating done");
    wr(A_IRQ_EN1, 8'h91);
    for (int r = 0; r < 4; r++) begin
      kind = (r + 1) / 2;
      persist_long <= (r >= 2);
      n = (kind == 0) ? 8 : ((r >= 2) ? 5 : 3);
      v = 16'($random(seed)) | 16'h0001;
      if (kind == 0) v[15:8] = 8'h00;
      if (v == cur[kind]) v[1] = ~v[1];
      w = ~v;
      for (int j = 0; j < n - 1; j++) send(kind, v);
      send(kind, w);
      got = (kind == 0) ? {8'h00, s1_value} : ((kind == 1) ? k1k2_value : tr_value);
      chk("value early", cur[kind], got);
      for (int j = 0; j < n - 1; j++) send(kind, v);
      exp_irq.push_back("accept");
      send(kind, v);
      step(3);
      got = (kind == 0) ? {8'h00, s1_value} : ((kind == 1) ? k1k2_value : tr_value);
      chk("value accepted", v, got);
      cur[kind] = v;
    end
    $display("test persistence done");
    step(3);
    wrap_up;
  end
endmodule
